//--- bench/cfg_arbiter_model.sv
// Model of the shared port arbiter, with adjustable grant delay
`timescale 1ns/10ps

module cfg_arbiter_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       req_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       other_i,
    output logic            gnt_o,
    output logic            rel_o
);
    logic [3:0] wait_reg;
    logic       pend_reg;

    // A competing requester stays pending until the block has yielded once
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) pend_reg <= 1'b0;
        else if (other_i) pend_reg <= 1'b1;
        else if (rel_o && !req_i) pend_reg <= 1'b0;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnt_o    <= 1'b0;
            rel_o    <= 1'b0;
            wait_reg <= 4'h0;
        end else if (!req_i) begin
            gnt_o    <= 1'b0;
            rel_o    <= 1'b0;
            wait_reg <= 4'h0;
        end else if (!gnt_o) begin
            if (wait_reg == delay_i) begin
                gnt_o <= 1'b1;
                rel_o <= pend_reg;
            end else wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : cfg_arbiter_model

//--- bench/config_port_access_handshake_asserts.sv
// Port-level assertions for the configuration port requester
`timescale 1ns/10ps
`include "cfg_port_defines.svh"

module config_port_access_handshake_asserts #(
    parameter bit arbitration_enable_param = 1'b1,
    parameter bit newer_family_param       = 1'b1,
    parameter bit reset_active_high_param  = 1'b1
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   port_reset_i,
    input  wire logic [`CFG_RESP_W-1:0] s_axi_reg_bresp_o,
    input  wire logic                   s_axi_reg_bvalid_o,
    input  wire logic                   s_axi_reg_bready_i,
    input  wire logic [`CFG_DATA_W-1:0] port_data_o,
    input  wire logic                   port_sel_n_o,
    input  wire logic                   port_rdwr_n_o,
    input  wire logic                   port_avail_i,
    input  wire logic                   port_req_o,
    input  wire logic                   port_gnt_i,
    input  wire logic                   port_rel_i,
    input  wire logic                   port_owned_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic port_rst_act = (port_reset_i == reset_active_high_param);

    a_req_unused: assert property (arbitration_enable_param || !port_req_o)
        else $error("request raised with arbitration off");
    a_sel_after_req: assert property (arbitration_enable_param && !port_sel_n_o |-> $past(port_req_o))
        else $error("port write without a pending request");
    a_sel_needs_gnt: assert property (arbitration_enable_param && !port_sel_n_o |-> $past(port_gnt_i))
        else $error("chip select without grant");
    a_sel_needs_avail: assert property (newer_family_param && !port_sel_n_o |-> $past(port_avail_i))
        else $error("port write while the port was busy");
    a_rel_yield: assert property (arbitration_enable_param && port_owned_o && port_rel_i |-> ##[1:4] !port_req_o)
        else $error("request held after release");
    a_sel_pulse: assert property (!port_sel_n_o |=> port_sel_n_o)
        else $error("chip select low for more than one cycle");
    a_sel_write: assert property (!port_sel_n_o |-> !port_rdwr_n_o)
        else $error("port access not marked as write");
    a_data_idle: assert property (port_sel_n_o |-> port_data_o == `CFG_DATA_IDLE)
        else $error("port data driven while deselected");
    a_bresp_code: assert property (s_axi_reg_bvalid_o |-> s_axi_reg_bresp_o inside {2'h0, 2'h2})
        else $error("unexpected write response code");
    a_bvalid_hold: assert property (s_axi_reg_bvalid_o && !s_axi_reg_bready_i |=>
        s_axi_reg_bvalid_o && $stable(s_axi_reg_bresp_o))
        else $error("write response dropped before ready");
    a_rst_quiet: assert property (port_rst_act |=> !port_req_o && port_sel_n_o && port_data_o == 32'h0)
        else $error("port outputs active after synchronous reset");

    c_yield: cover property (port_owned_o && port_rel_i ##[1:4] !port_req_o);
    c_word: cover property (!port_sel_n_o);
    c_slverr: cover property (s_axi_reg_bvalid_o && s_axi_reg_bresp_o == 2'h2);
endmodule : config_port_access_handshake_asserts

bind config_port_access_handshake config_port_access_handshake_asserts #(
    .arbitration_enable_param(arbitration_enable_param),
    .newer_family_param      (newer_family_param),
    .reset_active_high_param (reset_active_high_param)
) i_config_port_access_handshake_asserts (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .port_reset_i(port_reset_i),
    .s_axi_reg_bresp_o(s_axi_reg_bresp_o), .s_axi_reg_bvalid_o(s_axi_reg_bvalid_o),
    .s_axi_reg_bready_i(s_axi_reg_bready_i), .port_data_o(port_data_o), .port_sel_n_o(port_sel_n_o),
    .port_rdwr_n_o(port_rdwr_n_o), .port_avail_i(port_avail_i), .port_req_o(port_req_o), .port_gnt_i(port_gnt_i),
    .port_rel_i(port_rel_i), .port_owned_o(port_owned_o)
);

//--- bench/config_port_access_handshake_bench.sv
// Self-checking bench for the configuration port requester
`timescale 1ns/10ps

module config_port_access_handshake_bench;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, port_reset_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b1, done_in = 1'b0, err_in = 1'b0, clr = 1'b0, other = 1'b0, req_d = 1'b0;
    logic avail = 1'b1, sel2_n, req2, done2, err2;
    logic [31:0] port_data2, last2;
    int seen2, lat, avail_lo = 0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, seen_q[$];
    logic [3:0]  delay = 4'h0;
    logic [1:0]  bresp, resp;
    logic [31:0] port_data;
    logic awready, wready, bvalid, sel_n, req, gnt, rel, done_o, err_o;
    int fail_count = 0, cmp_count = 0, waits, yield_cnt;

    always #5 mclk_i = ~mclk_i;

    config_port_access_handshake i_config_port_access_handshake (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .port_reset_i(port_reset_i),
        .s_axi_reg_awaddr_i(awaddr), .s_axi_reg_awvalid_i(awvalid), .s_axi_reg_awready_o(awready),
        .s_axi_reg_wdata_i(wdata), .s_axi_reg_wvalid_i(wvalid), .s_axi_reg_wready_o(wready),
        .s_axi_reg_bresp_o(bresp), .s_axi_reg_bvalid_o(bvalid), .s_axi_reg_bready_i(bready),
        .port_data_o(port_data), .port_sel_n_o(sel_n), .port_rdwr_n_o(),
        .port_avail_i(avail), .port_done_i(done_in), .port_error_i(err_in),
        .port_req_o(req), .port_gnt_i(gnt), .port_rel_i(rel), .status_clear_i(clr),
        .reconfig_done_o(done_o), .reconfig_error_o(err_o), .port_owned_o());
    // Second copy with both options off and the other reset level; grant and release tied against it
    config_port_access_handshake #(
        .arbitration_enable_param(1'b0), .newer_family_param(1'b0), .reset_active_high_param(1'b0)
    ) i_config_port_access_handshake_plain (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .port_reset_i(!port_reset_i),
        .s_axi_reg_awaddr_i(awaddr), .s_axi_reg_awvalid_i(awvalid), .s_axi_reg_awready_o(),
        .s_axi_reg_wdata_i(wdata), .s_axi_reg_wvalid_i(wvalid), .s_axi_reg_wready_o(),
        .s_axi_reg_bresp_o(), .s_axi_reg_bvalid_o(), .s_axi_reg_bready_i(bready),
        .port_data_o(port_data2), .port_sel_n_o(sel2_n), .port_rdwr_n_o(),
        .port_avail_i(avail), .port_done_i(done_in), .port_error_i(err_in),
        .port_req_o(req2), .port_gnt_i(1'b0), .port_rel_i(1'b1), .status_clear_i(clr),
        .reconfig_done_o(done2), .reconfig_error_o(err2), .port_owned_o());
    cfg_arbiter_model i_cfg_arbiter_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
        .delay_i(delay), .other_i(other), .gnt_o(gnt), .rel_o(rel));

    // Sample on the falling edge so outputs launched at the rising edge have settled
    always @(negedge mclk_i) begin
        if (sel_n === 1'b0) seen_q.push_back(port_data);
        if (sel2_n === 1'b0) begin
            seen2++;
            last2 = port_data2;
        end
        if (req === 1'b0 && req_d && rel === 1'b1) yield_cnt++;
        req_d = (req === 1'b1);
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_write(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp_resp,
                            input int exp_words);
        int n;
        logic b_ok;
        b_ok = 1'b0;
        waits = 0;
        seen2 = 0;
        seen_q.delete();
        @(posedge mclk_i);
        awaddr  <= addr;
        wdata   <= data;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 100 && !b_ok; n++) begin
            @(posedge mclk_i);
            avail <= (n >= avail_lo);
            if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
            if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
            if (req === 1'b1 && gnt === 1'b0) waits++;
            if (bvalid === 1'b1) begin
                b_ok = 1'b1;
                resp = bresp;
            end
        end
        lat = n;
        if (!b_ok) begin
            fail_count++;
            $display("[ERR] %0t no write response", $time);
            summarize();
        end else begin
            repeat (3) @(posedge mclk_i);
            chk({30'h0, resp}, {30'h0, exp_resp});
            chk(seen_q.size(), exp_words);
            chk(seen2, exp_words);
            if (exp_words == 1) begin
                chk(seen_q[0], data);
                chk(last2, data);
            end
        end
    endtask : do_write

    task automatic t_slow_grant();
        delay <= 4'h6;
        do_write(32'h0, 32'h5a5a_c3c3, 2'h0, 1);
        chk({31'h0, waits >= 6}, 32'h1);
        delay <= 4'h0;
        $display("slow grant done");
    endtask : t_slow_grant

    task automatic t_release();
        yield_cnt = 0;
        @(posedge mclk_i);
        other <= 1'b1;
        @(posedge mclk_i);
        other <= 1'b0;
        do_write(32'h0, 32'h1234_fedc, 2'h0, 1);
        chk(yield_cnt, 1);
        $display("release done");
    endtask : t_release

    // Port busy for the first 20 cycles: the word must wait for it
    task automatic t_avail();
        avail_lo = 20;
        do_write(32'h0, 32'h0bad_f00d, 2'h0, 1);
        chk({31'h0, lat > avail_lo}, 32'h1);
        avail_lo = 0;
        $display("port busy done");
    endtask : t_avail

    task automatic t_port_reset();
        @(posedge mclk_i);
        port_reset_i <= 1'b1;
        @(posedge mclk_i);
        port_reset_i <= 1'b0;
        @(negedge mclk_i);
        chk({28'h0, req, sel_n, req2, sel2_n}, {28'h0, 4'b0101});
        chk(port_data, 32'h0);
        do_write(32'h0, 32'h0000_0001, 2'h0, 1);
        $display("port reset done");
    endtask : t_port_reset

    task automatic t_status(input bit use_err);
        @(posedge mclk_i);
        {err_in, done_in} <= use_err ? 2'b10 : 2'b01;
        @(posedge mclk_i);
        {err_in, done_in} <= 2'b00;
        repeat (2) @(posedge mclk_i);
        chk({30'h0, err_o, done_o}, {30'h0, use_err, !use_err});
        chk({30'h0, err2, done2}, 32'h0);
        // Event and clear in one cycle: the event wins
        {err_in, done_in} <= use_err ? 2'b10 : 2'b01;
        clr <= 1'b1;
        @(posedge mclk_i);
        {err_in, done_in} <= 2'b00;
        clr <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({30'h0, err_o, done_o}, {30'h0, use_err, !use_err});
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({30'h0, err_o, done_o}, 32'h0);
        $display("status done");
    endtask : t_status

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        do_write(32'h0, 32'ha5a5_0f0f, 2'h0, 1);
        $display("basic write done");
        do_write(32'h0000_0010, 32'hdead_0001, 2'h2, 0);
        $display("bad address done");
        t_slow_grant();
        t_release();
        t_avail();
        t_port_reset();
        t_status(1'b0);
        t_status(1'b1);
        summarize();
    end
endmodule : config_port_access_handshake_bench

//--- hdl/cfg_port_defines.svh
// Constants for the configuration port requester and its write channel
// How it works
// - With the arbitration parameter at zero the request output stays low and grant and release are ignored.
// - With arbitration on, the request output is registered: it rises the cycle after a data word starts waiting for the port and stays low during a yield.
// - On release the block holds back the waiting word until granted again and drops its request.
// - The available, done and error inputs are used only when the newer-family parameter is set.
// - Port data, chip select and read/write select each come from a dedicated flip-flop output.
// - The write channel has a 32-bit address, 32-bit data and a 2-bit response with AXI4-Lite handshakes.
// - Port logic runs on the rising clock edge and has a synchronous reset whose level is a build option.
`ifndef CFG_PORT_DEFINES_SVH
`define CFG_PORT_DEFINES_SVH

`define CFG_ADDR_W        32
`define CFG_DATA_W        32
`define CFG_RESP_W        2
`define CFG_WORD_OFFSET   32'h0000_0000
`define CFG_ADDR_MASK     32'h0000_0ffc
`define CFG_RESP_OKAY     2'h0
`define CFG_RESP_SLVERR   2'h2
`define CFG_DATA_IDLE     32'h0000_0000

`endif

//--- hdl/cfg_port_pkg.sv
// Types shared by the configuration port requester
package cfg_port_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_OWN   = 2'b10,
        ST_YIELD = 2'b11
    } port_state_type;

endpackage : cfg_port_pkg

//--- hdl/cfg_word_if.sv
// Word hand-off from the write channel to the port sequencer
`timescale 1ns/10ps
`include "cfg_port_defines.svh"

interface cfg_word_if;
    logic                   valid;
    logic                   ready;
    logic [`CFG_DATA_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cfg_word_if

//--- hdl/cfg_write_slave.sv
// AXI4-Lite write channel that turns each accepted write to the word address into one port word
`timescale 1ns/10ps
`include "cfg_port_defines.svh"

module cfg_write_slave (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [`CFG_ADDR_W-1:0] awaddr_i,
    input  wire logic                   awvalid_i,
    output logic                        awready_o,
    input  wire logic [`CFG_DATA_W-1:0] wdata_i,
    input  wire logic                   wvalid_i,
    output logic                        wready_o,
    output logic [`CFG_RESP_W-1:0]      bresp_o,
    output logic                        bvalid_o,
    input  wire logic                   bready_i,
    cfg_word_if.src                     word
);

    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic                   addr_ok_reg;
    logic [`CFG_DATA_W-1:0] data_reg;
    logic                   word_valid_reg;
    logic                   bvalid_reg;
    logic [`CFG_RESP_W-1:0] bresp_reg;
    logic                   aw_take;
    logic                   w_take;
    logic                   b_done;
    logic                   launch;
    logic                   awready_reg;
    logic                   wready_reg;

    assign aw_take = awvalid_i && !aw_held_reg;
    assign w_take  = wvalid_i && !w_held_reg;
    assign b_done  = bvalid_reg && bready_i;
    // One transaction at a time: both halves held, nothing outstanding
    assign launch  = aw_held_reg && w_held_reg && !word_valid_reg && !bvalid_reg;

    assign awready_o  = awready_reg;
    assign wready_o   = wready_reg;
    assign bvalid_o   = bvalid_reg;
    assign bresp_o    = bresp_reg;
    assign word.valid = word_valid_reg;
    assign word.data  = data_reg;

    // Ready has its own flop so the pin comes straight from a register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            addr_ok_reg <= 1'b0;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            addr_ok_reg <= ((awaddr_i & `CFG_ADDR_MASK) == `CFG_WORD_OFFSET);
        end else if (b_done) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
            data_reg   <= `CFG_DATA_IDLE;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            data_reg   <= wdata_i;
        end else if (b_done) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_valid_reg <= 1'b0;
        end else if (launch && addr_ok_reg) begin
            word_valid_reg <= 1'b1;
        end else if (word_valid_reg && word.ready) begin
            word_valid_reg <= 1'b0;
        end
    end

    // The response waits for the port, so back-pressure reaches the writer
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `CFG_RESP_OKAY;
        end else if (launch && !addr_ok_reg) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= `CFG_RESP_SLVERR;
        end else if (word_valid_reg && word.ready) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= `CFG_RESP_OKAY;
        end else if (b_done) begin
            bvalid_reg <= 1'b0;
        end
    end

endmodule : cfg_write_slave

//--- hdl/config_port_access_handshake.sv
// Requester for the shared configuration access port, with optional arbitration
`timescale 1ns/10ps
`include "cfg_port_defines.svh"

module config_port_access_handshake #(
    parameter bit arbitration_enable_param = 1'b1,
    parameter bit newer_family_param       = 1'b1,
    parameter bit reset_active_high_param  = 1'b1
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   port_reset_i,
    // Register-bus write channel
    input  wire logic [`CFG_ADDR_W-1:0] s_axi_reg_awaddr_i,
    input  wire logic                   s_axi_reg_awvalid_i,
    output logic                        s_axi_reg_awready_o,
    input  wire logic [`CFG_DATA_W-1:0] s_axi_reg_wdata_i,
    input  wire logic                   s_axi_reg_wvalid_i,
    output logic                        s_axi_reg_wready_o,
    output logic [`CFG_RESP_W-1:0]      s_axi_reg_bresp_o,
    output logic                        s_axi_reg_bvalid_o,
    input  wire logic                   s_axi_reg_bready_i,
    // Configuration port pins
    output logic [`CFG_DATA_W-1:0]      port_data_o,
    output logic                        port_sel_n_o,
    output logic                        port_rdwr_n_o,
    input  wire logic                   port_avail_i,
    input  wire logic                   port_done_i,
    input  wire logic                   port_error_i,
    // Arbiter handshake
    output logic                        port_req_o,
    input  wire logic                   port_gnt_i,
    input  wire logic                   port_rel_i,
    // Status
    input  wire logic                   status_clear_i,
    output logic                        reconfig_done_o,
    output logic                        reconfig_error_o,
    output logic                        port_owned_o
);

    cfg_word_if word ();

    cfg_port_pkg::port_state_type state_reg;
    cfg_port_pkg::port_state_type state_next;

    logic                   sync_rst;
    logic                   gnt_eff;
    logic                   rel_eff;
    logic                   avail_eff;
    logic                   take;
    logic                   req_reg;
    logic                   sel_n_reg;
    logic                   rdwr_n_reg;
    logic [`CFG_DATA_W-1:0] data_reg;
    logic                   done_reg;
    logic                   error_reg;
    logic                   owned_reg;
    logic                   own_next;

    cfg_write_slave u_write (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .awaddr_i  (s_axi_reg_awaddr_i),
        .awvalid_i (s_axi_reg_awvalid_i),
        .awready_o (s_axi_reg_awready_o),
        .wdata_i   (s_axi_reg_wdata_i),
        .wvalid_i  (s_axi_reg_wvalid_i),
        .wready_o  (s_axi_reg_wready_o),
        .bresp_o   (s_axi_reg_bresp_o),
        .bvalid_o  (s_axi_reg_bvalid_o),
        .bready_i  (s_axi_reg_bready_i),
        .word      (word)
    );

    assign sync_rst = reset_active_high_param ? port_reset_i : !port_reset_i;

    // Fixed port lists cannot drop pins, so the disabled options ignore them instead
    generate
        if (arbitration_enable_param == 1'b0) begin : g_no_arb
            assign gnt_eff = 1'b1;
            assign rel_eff = 1'b0;
        end else begin : g_arb
            assign gnt_eff = port_gnt_i;
            assign rel_eff = port_rel_i;
        end
        if (newer_family_param == 1'b0) begin : g_old_family
            assign avail_eff = 1'b1;
        end else begin : g_new_family
            assign avail_eff = port_avail_i;
        end
    endgenerate

    // A word goes out only while owned, granted, available and not asked to yield
    assign take       = (state_reg == cfg_port_pkg::ST_OWN) && word.valid &&
                        gnt_eff && avail_eff && !rel_eff;
    assign word.ready = take;

    // YIELD costs one idle cycle so the arbiter always sees the request low
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cfg_port_pkg::ST_IDLE: begin
                if (word.valid) begin
                    state_next = cfg_port_pkg::ST_WAIT;
                end
            end
            cfg_port_pkg::ST_WAIT: begin
                if (gnt_eff) begin
                    state_next = cfg_port_pkg::ST_OWN;
                end
            end
            cfg_port_pkg::ST_OWN: begin
                // Losing grant here only stalls; the arbiter keeps it until the request drops
                if (rel_eff) begin
                    state_next = cfg_port_pkg::ST_YIELD;
                end else if (!word.valid) begin
                    state_next = cfg_port_pkg::ST_IDLE;
                end
            end
            cfg_port_pkg::ST_YIELD: begin
                state_next = cfg_port_pkg::ST_IDLE;
            end
        endcase
    end

    // Ownership as it stands after this edge, shared by the direction and status flops
    assign own_next = (state_next == cfg_port_pkg::ST_OWN) && gnt_eff;

    // The port reset clears the sequencer, port pins and status flags; the write channel keeps its state
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= cfg_port_pkg::ST_IDLE;
        end else if (sync_rst) begin
            state_reg <= cfg_port_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request follows the sequencer so it falls in the cycle after release is seen
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_reg <= 1'b0;
        end else if (sync_rst) begin
            req_reg <= 1'b0;
        end else begin
            req_reg <= arbitration_enable_param &&
                       ((state_next == cfg_port_pkg::ST_WAIT) || (state_next == cfg_port_pkg::ST_OWN));
        end
    end

    // Chip select is a one-cycle low pulse for each word taken
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_n_reg <= 1'b1;
        end else if (sync_rst) begin
            sel_n_reg <= 1'b1;
        end else begin
            sel_n_reg <= !take;
        end
    end

    // Data bus is parked at zero when not writing to keep stale words off the port
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_reg <= `CFG_DATA_IDLE;
        end else if (sync_rst) begin
            data_reg <= `CFG_DATA_IDLE;
        end else begin
            data_reg <= take ? word.data : `CFG_DATA_IDLE;
        end
    end

    // Write direction is held only while the port belongs to us
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdwr_n_reg <= 1'b1;
        end else if (sync_rst) begin
            rdwr_n_reg <= 1'b1;
        end else begin
            rdwr_n_reg <= !own_next;
        end
    end

    // Ownership flag for status, registered like every other pin
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            owned_reg <= 1'b0;
        end else if (sync_rst) begin
            owned_reg <= 1'b0;
        end else begin
            owned_reg <= own_next;
        end
    end

    // Sticky done flag; a new event beats a clear in the same cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
        end else if (sync_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (newer_family_param && port_done_i) || (done_reg && !status_clear_i);
        end
    end

    // Sticky error flag, same precedence as the done flag
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            error_reg <= 1'b0;
        end else if (sync_rst) begin
            error_reg <= 1'b0;
        end else begin
            error_reg <= (newer_family_param && port_error_i) || (error_reg && !status_clear_i);
        end
    end

    assign port_req_o       = req_reg;
    assign port_sel_n_o     = sel_n_reg;
    assign port_data_o      = data_reg;
    assign port_rdwr_n_o    = rdwr_n_reg;
    assign port_owned_o     = owned_reg;
    assign reconfig_done_o  = done_reg;
    assign reconfig_error_o = error_reg;

endmodule : config_port_access_handshake
